// ### verilog/gpio_port_pkg.sv
// Constants, field layouts and carrier types of the 16-pin port data and lock block.
//
// Summary of operation
// RULE_01 - Input register bits 15:0 show pin levels.
// RULE_02 - Input register upper half always reads zero.
// RULE_03 - Output register holds 16 drive values, resets zero.
// RULE_04 - Software uses only full 32-bit word accesses.
// RULE_05 - Set/clear low half ones set output bits.
// RULE_06 - Set/clear high half ones clear output bits.
// RULE_07 - Set wins when set and clear coincide.
// RULE_08 - Clear-only register ones clear output bits.
// RULE_09 - Lock register bits 15:0 mark protected pins.
// RULE_10 - Lock bits writable only while key reads zero.
// RULE_11 - Active key reads one, freezes lock until reset.
// RULE_12 - Key sequence: write 1,0,1, read 0, read 1.
// RULE_13 - Changed bits or misorder never activate protection.
// RULE_14 - Locked pins ignore configuration writes until reset.
// RULE_15 - Per pin: 2-bit mode, 2-bit function fields.
// RULE_16 - Both configuration registers reset to 0x44444444.
// RULE_17 - Pin levels sampled every clock into input register.
// RULE_18 - Reserved bits read zero, writes ignored.
// RULE_19 - Misordered lock access returns tracker to idle.
package gpio_port_pkg;

   // ****************************************
   // Sizes and register offsets
   // ****************************************
   localparam int          PIN_COUNT        = 16;
   localparam int          ADDR_W           = 8;
   localparam logic [7:0]  OFS_CFG_LOWER    = 8'h00;
   localparam logic [7:0]  OFS_CFG_UPPER    = 8'h04;
   localparam logic [7:0]  OFS_INPUT_LEVEL  = 8'h08;
   localparam logic [7:0]  OFS_OUTPUT_VALUE = 8'h0C;
   localparam logic [7:0]  OFS_SET_CLEAR    = 8'h10;
   localparam logic [7:0]  OFS_CLEAR_ONLY   = 8'h14;
   localparam logic [7:0]  OFS_CONFIG_LOCK  = 8'h18;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [31:0] RST_CONFIG       = 32'h4444_4444;
   localparam logic [15:0] RST_OUTPUT_VALUE = 16'h0000;
   localparam logic [15:0] RST_LOCK_BITS    = 16'h0000;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int          SET_REQ_LSB      = 0;
   localparam int          CLR_REQ_LSB      = 16;
   localparam int          LOCK_KEY_POS     = 16;
   localparam int          NIBBLE_W         = 4;
   localparam int          DIR_SPEED_LSB    = 0;
   localparam int          FUNC_SEL_LSB     = 2;
   localparam int          FUNC_OPEN_DRAIN  = 0;
   localparam logic [1:0]  DIR_INPUT        = 2'h0;
   localparam logic [1:0]  FUNC_ANALOG      = 2'h0;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      LK_IDLE,
      LK_WROTE_ONE,
      LK_WROTE_ZERO,
      LK_WROTE_ONE_AGAIN,
      LK_READ_ZERO
   } lock_phase_t;

   typedef struct packed {
      logic              sel;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
   } reg_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } reg_rsp_t;

   typedef struct packed {
      logic [PIN_COUNT-1:0] level_out;
      logic [PIN_COUNT-1:0] drive_en;
   } pin_drive_t;

endpackage

// ### verilog/pin_level_sync.sv
// Two-stage synchroniser for the port pin levels.
`timescale 1ns/1ps
`default_nettype none
module pin_level_sync
   import gpio_port_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 srst,
   input  wire logic [PIN_COUNT-1:0] pin_raw,
   output var  logic [PIN_COUNT-1:0] pin_synced
);

   typedef struct packed {
      logic [PIN_COUNT-1:0] first_ff;
      logic [PIN_COUNT-1:0] second_ff;
   } sync_state_t;

   sync_state_t st_ff;
   sync_state_t nxt_st;

   // The first stage feeds only the second stage.
   always_comb begin
      nxt_st           = st_ff;
      nxt_st.first_ff  = pin_raw;
      nxt_st.second_ff = st_ff.first_ff;
   end

   // Registers both stages.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pin_synced = st_ff.second_ff;

endmodule
`default_nettype wire

// ### verilog/lock_key_tracker.sv
// Lock bits, lock key and the keyed activation sequence tracker.
`timescale 1ns/1ps
`default_nettype none
module lock_key_tracker
   import gpio_port_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 srst,
   input  wire logic                 acc_write,
   input  wire logic                 acc_read,
   input  wire logic                 wr_key,
   input  wire logic [PIN_COUNT-1:0] wr_bits,
   output var  logic [PIN_COUNT-1:0] lock_bits,
   output var  logic                 key_active
);

   typedef struct packed {
      lock_phase_t          phase;
      logic [PIN_COUNT-1:0] bits;
      logic                 key;
   } lock_state_t;

   lock_state_t st_ff;
   lock_state_t nxt_st;
   logic        same_bits;

   always_comb begin
      nxt_st    = st_ff;
      same_bits = (wr_bits == st_ff.bits);
      // RULE_11 frozen once active
      if (!st_ff.key) begin
         // RULE_10 bits writable while unkeyed
         if (acc_write) begin
            nxt_st.bits = wr_bits;
         end
         // RULE_12 key sequence steps
         unique case (st_ff.phase)
            LK_IDLE: begin
               if (acc_write && wr_key) begin
                  nxt_st.phase = LK_WROTE_ONE;
               end
            end
            LK_WROTE_ONE: begin
               // RULE_13 unchanged bits required
               if (acc_write && !wr_key && same_bits) begin
                  nxt_st.phase = LK_WROTE_ZERO;
               end else if (acc_write || acc_read) begin
                  // RULE_19 misorder restarts tracker
                  nxt_st.phase = (acc_write && wr_key) ? LK_WROTE_ONE : LK_IDLE;
               end
            end
            LK_WROTE_ZERO: begin
               if (acc_write && wr_key && same_bits) begin
                  nxt_st.phase = LK_WROTE_ONE_AGAIN;
               end else if (acc_write || acc_read) begin
                  nxt_st.phase = (acc_write && wr_key) ? LK_WROTE_ONE : LK_IDLE;
               end
            end
            LK_WROTE_ONE_AGAIN: begin
               if (acc_read) begin
                  nxt_st.phase = LK_READ_ZERO;
               end else if (acc_write) begin
                  nxt_st.phase = wr_key ? LK_WROTE_ONE : LK_IDLE;
               end
            end
            LK_READ_ZERO: begin
               // RULE_12 second read activates key
               if (acc_read) begin
                  nxt_st.key   = 1'b1;
                  nxt_st.phase = LK_IDLE;
               end else if (acc_write) begin
                  nxt_st.phase = wr_key ? LK_WROTE_ONE : LK_IDLE;
               end
            end
         endcase
      end
   end

   // Registers the tracker; only system reset clears an active key.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_ff.phase <= LK_IDLE;
         st_ff.bits  <= RST_LOCK_BITS;
         st_ff.key   <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign lock_bits  = st_ff.bits;
   // RULE_12 key visible to completing read
   // The key shows its next value, so the read that ends the sequence
   // already returns it set; only one access is taken per cycle, so no
   // configuration write can meet this early key.
   assign key_active = nxt_st.key;

endmodule
`default_nettype wire

// ### verilog/gpio_data_and_lock_port.sv
// Top of the 16-pin port: configuration, data, set/clear and lock registers.
`timescale 1ns/1ps
`default_nettype none
module gpio_data_and_lock_port
   import gpio_port_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 srst,
   input  wire reg_req_t             bus_req,
   output var  reg_rsp_t             bus_rsp,
   input  wire logic [PIN_COUNT-1:0] pin_in,
   output var  pin_drive_t           pin_drive
);

   // ****************************************
   // Overview
   // ****************************************

   // Each selected bus cycle is one whole-word access, taken at the edge
   // where sel is high and answered by a one-cycle ack at the next edge.
   // Output values change at the edge that takes the write, so the pin
   // drive and the ack appear together and no half-done update is seen.
   // Pin levels pass a two-stage synchroniser and one more register, so a
   // read sees a pin change four clock edges after it reaches the pin.
   // The lock key is cleared only by system reset; once it is set, no bus
   // access reaches the lock bits or the nibbles of protected pins.
   // Unmapped offsets are acknowledged and read zero, so a wrong address
   // never stalls the bus.
   // A write to the input level offset is acknowledged and changes nothing.
   // Open-drain outputs release the pin while the output bit is high, so
   // the input register then shows what the outside circuit holds there.
   // Analog input pins read zero because their input stage is off.

   // ****************************************
   // Helper functions
   // ****************************************

   // Returns the configuration nibble of one pin from the two registers.
   function automatic logic [3:0] pin_nibble(
      input logic [31:0] lower,
      input logic [31:0] upper,
      input int          pin
   );
      logic [31:0] src;
      int          idx;
      src = (pin < 8) ? lower : upper;
      idx = (pin % 8) * NIBBLE_W;
      return src[idx +: NIBBLE_W];
   endfunction

   // Merges a configuration write, keeping the nibbles of protected pins.
   function automatic logic [31:0] merge_config(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [7:0]  protect
   );
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 8; i++) begin
         if (!protect[i]) begin
            res[i*NIBBLE_W +: NIBBLE_W] = new_val[i*NIBBLE_W +: NIBBLE_W];
         end
      end
      return res;
   endfunction

   // True when the mode field selects input; other codes are output speeds.
   function automatic logic mode_is_input(
      input logic [3:0] nibble
   );
      return nibble[DIR_SPEED_LSB +: 2] == DIR_INPUT;
   endfunction

   // True when an input pin is in analog mode, so its level reads as zero.
   function automatic logic nibble_is_analog(
      input logic [3:0] nibble
   );
      return mode_is_input(nibble) && (nibble[FUNC_SEL_LSB +: 2] == FUNC_ANALOG);
   endfunction

   // True when the pin buffer drives; an open-drain pin releases a high level.
   function automatic logic nibble_drives(
      input logic [3:0] nibble,
      input logic       level
   );
      return !mode_is_input(nibble) && !(nibble[FUNC_SEL_LSB + FUNC_OPEN_DRAIN] && level);
   endfunction

   // Builds the word returned by a read of the lock register.
   // Bits above the key are reserved and always read zero.
   function automatic logic [31:0] lock_word(
      input logic                 key,
      input logic [PIN_COUNT-1:0] bits
   );
      logic [31:0] word;
      word                = '0;
      word[LOCK_KEY_POS]  = key;
      word[PIN_COUNT-1:0] = bits;
      return word;
   endfunction

   // Widens a pin vector to a bus word with a zero upper half.
   function automatic logic [31:0] pin_word(
      input logic [PIN_COUNT-1:0] bits
   );
      return {16'h0000, bits};
   endfunction

   // ****************************************
   // State
   // ****************************************

   typedef struct packed {
      logic [31:0]          cfg_lower;
      logic [31:0]          cfg_upper;
      logic [PIN_COUNT-1:0] out_value;
      logic [PIN_COUNT-1:0] in_level;
      reg_rsp_t             rsp;
      pin_drive_t           drive;
   } port_state_t;

   port_state_t st_ff;
   port_state_t nxt_st;

   logic [PIN_COUNT-1:0] pin_synced;
   logic [PIN_COUNT-1:0] lock_bits;
   logic                 key_active;
   logic                 wr_take;
   logic                 rd_take;
   logic                 hit_lock;
   logic [PIN_COUNT-1:0] protect_mask;
   logic [PIN_COUNT-1:0] set_req;
   logic [PIN_COUNT-1:0] clr_req;
   logic [3:0]           nib;
   logic [PIN_COUNT-1:0] analog_mask;

   // ****************************************
   // Submodules
   // ****************************************

   // Brings the pin levels into the clock domain.
   pin_level_sync u_pin_sync (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .pin_raw    (pin_in),
      .pin_synced (pin_synced)
   );

   // Keeps the lock bits and runs the activation sequence.
   lock_key_tracker u_lock (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .acc_write  (wr_take && hit_lock),
      .acc_read   (rd_take && hit_lock),
      .wr_key     (bus_req.wdata[LOCK_KEY_POS]),
      .wr_bits    (bus_req.wdata[PIN_COUNT-1:0]),
      .lock_bits  (lock_bits),
      .key_active (key_active)
   );

   // ****************************************
   // Access decode
   // ****************************************

   // Every selected cycle is one full word access, taken at once.
   assign wr_take  = bus_req.sel && bus_req.write;
   assign rd_take  = bus_req.sel && !bus_req.write;
   assign hit_lock = (bus_req.addr == OFS_CONFIG_LOCK);

   // RULE_14 locked pins protected once active
   assign protect_mask = key_active ? lock_bits : '0;

   // RULE_05 set half of the strobe word
   assign set_req = bus_req.wdata[SET_REQ_LSB +: PIN_COUNT];
   // RULE_06 clear half of the strobe word
   assign clr_req = bus_req.wdata[CLR_REQ_LSB +: PIN_COUNT];

   // ****************************************
   // Next-state logic
   // ****************************************

   // Computes registers, read data and pin drive for the next cycle.
   always_comb begin
      nxt_st      = st_ff;
      nib         = '0;
      analog_mask = '0;

      // Pins in analog input mode read as zero.
      for (int p = 0; p < PIN_COUNT; p++) begin
         nib = pin_nibble(st_ff.cfg_lower, st_ff.cfg_upper, p);
         analog_mask[p] = nibble_is_analog(nib);
      end

      // RULE_17 sample pins every cycle
      nxt_st.in_level = pin_synced & ~analog_mask;

      // ****************************************
      // Write side
      // ****************************************

      // Write side effects of the register map.
      if (wr_take) begin
         unique case (bus_req.addr)
            OFS_CFG_LOWER: begin
               // RULE_14 skip locked nibbles
               nxt_st.cfg_lower = merge_config(st_ff.cfg_lower, bus_req.wdata,
                                               protect_mask[7:0]);
            end
            OFS_CFG_UPPER: begin
               nxt_st.cfg_upper = merge_config(st_ff.cfg_upper, bus_req.wdata,
                                               protect_mask[15:8]);
            end
            OFS_OUTPUT_VALUE: begin
               // RULE_03 direct output write
               nxt_st.out_value = bus_req.wdata[PIN_COUNT-1:0];
            end
            OFS_SET_CLEAR: begin
               // RULE_07 set applied after clear
               nxt_st.out_value = (st_ff.out_value & ~clr_req) | set_req;
            end
            OFS_CLEAR_ONLY: begin
               // RULE_08 clear-only strobe
               nxt_st.out_value = st_ff.out_value & ~bus_req.wdata[PIN_COUNT-1:0];
            end
            default: begin
               // Input level, lock and unmapped offsets change nothing here.
               nxt_st.out_value = st_ff.out_value;
            end
         endcase
      end

      // ****************************************
      // Bus answer
      // ****************************************

      // Each taken access is answered one cycle later.
      nxt_st.rsp.ack   = bus_req.sel;
      nxt_st.rsp.rdata = '0;
      if (rd_take) begin
         unique case (bus_req.addr)
            OFS_CFG_LOWER: begin
               nxt_st.rsp.rdata = st_ff.cfg_lower;
            end
            OFS_CFG_UPPER: begin
               nxt_st.rsp.rdata = st_ff.cfg_upper;
            end
            OFS_INPUT_LEVEL: begin
               // RULE_01 RULE_02 levels low, zero high
               nxt_st.rsp.rdata = pin_word(st_ff.in_level);
            end
            OFS_OUTPUT_VALUE: begin
               // RULE_18 reserved half reads zero
               nxt_st.rsp.rdata = pin_word(st_ff.out_value);
            end
            OFS_CONFIG_LOCK: begin
               // RULE_09 RULE_11 bits and key visible
               // RULE_12 completing read sees key set
               nxt_st.rsp.rdata = lock_word(key_active, lock_bits);
            end
            default: begin
               // Strobe registers and unmapped offsets read zero.
               nxt_st.rsp.rdata = '0;
            end
         endcase
      end

      // ****************************************
      // Pin drive
      // ****************************************

      // Pin drive follows the next output value and configuration.
      for (int p = 0; p < PIN_COUNT; p++) begin
         nib = pin_nibble(nxt_st.cfg_lower, nxt_st.cfg_upper, p);
         // RULE_15 mode and function decode
         nxt_st.drive.level_out[p] = nxt_st.out_value[p];
         nxt_st.drive.drive_en[p]  = nibble_drives(nib, nxt_st.out_value[p]);
      end
   end

   // ****************************************
   // State register
   // ****************************************

   // Registers all state; configuration resets to floating inputs.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         // RULE_16 floating input after reset
         st_ff.cfg_lower <= RST_CONFIG;
         st_ff.cfg_upper <= RST_CONFIG;
         st_ff.out_value <= RST_OUTPUT_VALUE;
         st_ff.in_level  <= '0;
         st_ff.rsp       <= '0;
         st_ff.drive     <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bus_rsp   = st_ff.rsp;
   assign pin_drive = st_ff.drive;

endmodule
`default_nettype wire

// ### verification/gpio_port_monitor.sv
// Concurrent checks on the bus answers and pin drive of the port block.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_monitor
   import gpio_port_pkg::*;
(
   input wire logic                 clk_sys,
   input wire logic                 srst,
   input wire reg_req_t             bus_req,
   input wire reg_rsp_t             bus_rsp,
   input wire logic [PIN_COUNT-1:0] pin_in,
   input wire pin_drive_t           pin_drive
);
   logic        lock_rd_ff;
   logic        key_seen_ff;
   logic [15:0] bits_seen_ff;
   wire logic        rd_req = bus_req.sel && !bus_req.write;
   wire logic        wr_req = bus_req.sel && bus_req.write;
   wire logic [15:0] lvl    = pin_drive.level_out;
   wire logic [15:0] wlo    = bus_req.wdata[15:0];
   wire logic [15:0] whi    = bus_req.wdata[31:16];

   // Remembers the lock word once a lock read has shown the key set.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         lock_rd_ff   <= 1'b0;
         key_seen_ff  <= 1'b0;
         bits_seen_ff <= 16'h0000;
      end else begin
         lock_rd_ff <= rd_req && (bus_req.addr == OFS_CONFIG_LOCK);
         if (bus_rsp.ack && lock_rd_ff && bus_rsp.rdata[16] && !key_seen_ff) begin
            key_seen_ff  <= 1'b1;
            bits_seen_ff <= bus_rsp.rdata[15:0];
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   property p_ack_follows; bus_req.sel |=> bus_rsp.ack; endproperty
   property p_no_stray_ack; !bus_req.sel |=> !bus_rsp.ack; endproperty
   property p_in_upper; rd_req && bus_req.addr == OFS_INPUT_LEVEL |=> bus_rsp.rdata[31:16] == 16'h0000; endproperty
   property p_out_read; rd_req && bus_req.addr == OFS_OUTPUT_VALUE |=> bus_rsp.rdata == {16'h0000, $past(lvl)}; endproperty
   property p_out_write; wr_req && bus_req.addr == OFS_OUTPUT_VALUE |=> lvl == $past(wlo); endproperty
   property p_set_clear; wr_req && bus_req.addr == OFS_SET_CLEAR |=> lvl == (($past(lvl) & ~$past(whi)) | $past(wlo)); endproperty
   property p_clear_only; wr_req && bus_req.addr == OFS_CLEAR_ONLY |=> lvl == ($past(lvl) & ~$past(wlo)); endproperty
   property p_lvl_hold; !wr_req |=> $stable(lvl); endproperty
   property p_lock_upper; rd_req && bus_req.addr == OFS_CONFIG_LOCK |=> bus_rsp.rdata[31:17] == 15'h0000; endproperty
   property p_key_sticky; bus_rsp.ack && lock_rd_ff && key_seen_ff |-> bus_rsp.rdata[16:0] == {1'b1, bits_seen_ff}; endproperty
   property p_write_zero; wr_req |=> bus_rsp.rdata == 32'h0000_0000; endproperty
   property p_reset; disable iff (1'b0) srst |=> !bus_rsp.ack && lvl == 16'h0000 && pin_drive.drive_en == 16'h0000; endproperty

   a_ack_follows: assert property (p_ack_follows) else $error("access not acknowledged");
   a_no_stray_ack: assert property (p_no_stray_ack) else $error("ack without access");
   a_in_upper: assert property (p_in_upper) else $error("input upper half not zero");
   a_out_read: assert property (p_out_read) else $error("output read mismatch");
   a_out_write: assert property (p_out_write) else $error("output write mismatch");
   a_set_clear: assert property (p_set_clear) else $error("set clear result wrong");
   a_clear_only: assert property (p_clear_only) else $error("clear only result wrong");
   a_lvl_hold: assert property (p_lvl_hold) else $error("output changed without write");
   a_lock_upper: assert property (p_lock_upper) else $error("lock reserved bits set");
   a_key_sticky: assert property (p_key_sticky) else $error("active lock word changed");
   a_write_zero: assert property (p_write_zero) else $error("write ack data not zero");
   a_reset: assert property (p_reset) else $error("reset state wrong");

   c_key_set: cover property (bus_rsp.ack && lock_rd_ff && bus_rsp.rdata[16]);
   c_set_clear: cover property (wr_req && bus_req.addr == OFS_SET_CLEAR);
   c_in_read: cover property (rd_req && bus_req.addr == OFS_INPUT_LEVEL);
   c_upper_pins_high: cover property (rd_req && bus_req.addr == OFS_INPUT_LEVEL && pin_in[15:8] != 8'h00);
endmodule

bind gpio_data_and_lock_port gpio_port_monitor i_mon (
   .clk_sys  (clk_sys),
   .srst     (srst),
   .bus_req  (bus_req),
   .bus_rsp  (bus_rsp),
   .pin_in   (pin_in),
   .pin_drive(pin_drive)
);
`default_nettype wire

// ### verification/gpio_pin_partner.sv
// Model of the outside circuitry that drives or senses the port pins.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_partner
   import gpio_port_pkg::*;
(
   input  wire logic [PIN_COUNT-1:0] ext_level,
   input  wire pin_drive_t           pin_drive,
   output var  logic [PIN_COUNT-1:0] pin_in
);
   // A driven pin follows the port; a released pin takes the outside level.
   // pin levels seen
   always_comb begin
      pin_in = (pin_drive.level_out & pin_drive.drive_en) | (ext_level & ~pin_drive.drive_en);
   end
endmodule
`default_nettype wire

// ### verification/gpio_data_and_lock_port_tb_top.sv
// Self-checking bench of the port data and lock block.
`timescale 1ns/1ps
`default_nettype none
module gpio_data_and_lock_port_tb_top import gpio_port_pkg::*;;
   localparam logic [15:0] PULL = 16'hA5C3;
   localparam logic [15:0] DRV  = 16'h00FB;
   logic                 clk_sys;
   logic                 srst;
   reg_req_t             bus_req;
   reg_rsp_t             bus_rsp;
   logic [PIN_COUNT-1:0] pin_in;
   pin_drive_t           pin_drive;
   logic [PIN_COUNT-1:0] ext_level;
   int                   n_mismatch;
   int                   num_checks;

   gpio_data_and_lock_port i_dut (.clk_sys(clk_sys), .srst(srst), .bus_req(bus_req),
      .bus_rsp(bus_rsp), .pin_in(pin_in), .pin_drive(pin_drive));
   gpio_pin_partner i_pins (.ext_level(ext_level), .pin_drive(pin_drive), .pin_in(pin_in));

   // Free-running 20 MHz clock.
   always #25 clk_sys = ~clk_sys;

   // ****************************************
   // Access and compare tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, want, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      bus_req <= '{1'b1, 1'b1, a, d};
      @(posedge clk_sys);
      bus_req.sel <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      @(posedge clk_sys);
      bus_req <= '{1'b1, 1'b0, a, 32'h0000_0000};
      @(posedge clk_sys);
      bus_req.sel <= 1'b0;
      #1;
      chk($sformatf("ack %h", a), {31'h0000_0000, bus_rsp.ack}, 32'h0000_0001);
      chk($sformatf("read %h", a), bus_rsp.rdata, want);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Watchdog: the tests need some 100 cycles, so 5000 means a hang.
   initial begin
      #(50 * 5000);
      n_mismatch++;
      tally_and_finish();
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      srst = 1'b1;
      bus_req = '0;
      ext_level = PULL;
      n_mismatch = 0;
      num_checks = 0;
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      rd(OFS_OUTPUT_VALUE, 32'h0000_0000);
      rd(OFS_CONFIG_LOCK, 32'h0000_0000);
      rd(OFS_CFG_LOWER, 32'h4444_4444);
      rd(OFS_CFG_UPPER, 32'h4444_4444);
      rd(8'h1C, 32'h0000_0000);
      rd(OFS_INPUT_LEVEL, {16'h0000, PULL});
      wr(OFS_INPUT_LEVEL, 32'hFFFF_FFFF);
      ext_level <= 16'h5A3C;
      repeat (4) @(posedge clk_sys);
      rd(OFS_INPUT_LEVEL, 32'h0000_5A3C);
      ext_level <= PULL;
      wr(OFS_OUTPUT_VALUE, 32'hFFFF_1234);
      rd(OFS_OUTPUT_VALUE, 32'h0000_1234);
      wr(OFS_SET_CLEAR, 32'h0203_0003);
      rd(OFS_OUTPUT_VALUE, 32'h0000_1037);
      wr(OFS_CLEAR_ONLY, 32'hFFFF_0030);
      rd(OFS_OUTPUT_VALUE, 32'h0000_1007);
      wr(OFS_CFG_LOWER, 32'h1111_5511);
      repeat (4) @(posedge clk_sys);
      chk("drive_en", {16'h0000, pin_drive.drive_en}, {16'h0000, DRV});
      chk("level_out", {16'h0000, pin_drive.level_out}, 32'h0000_1007);
      rd(OFS_INPUT_LEVEL, {16'h0000, (16'h1007 & DRV) | (PULL & ~DRV)});
      wr(OFS_CONFIG_LOCK, 32'h0001_0001);
      wr(OFS_CONFIG_LOCK, 32'h0000_0003);
      wr(OFS_CONFIG_LOCK, 32'h0001_0003);
      rd(OFS_CONFIG_LOCK, 32'h0000_0003);
      rd(OFS_CONFIG_LOCK, 32'h0000_0003);
      wr(OFS_CONFIG_LOCK, 32'h0001_0001);
      wr(OFS_CONFIG_LOCK, 32'h0000_0001);
      wr(OFS_CONFIG_LOCK, 32'h0001_0001);
      rd(OFS_CONFIG_LOCK, 32'h0000_0001);
      rd(OFS_CONFIG_LOCK, 32'h0001_0001);
      rd(OFS_CONFIG_LOCK, 32'h0001_0001);
      wr(OFS_CONFIG_LOCK, 32'h0000_00FF);
      rd(OFS_CONFIG_LOCK, 32'h0001_0001);
      wr(OFS_CFG_LOWER, 32'h2222_2222);
      rd(OFS_CFG_LOWER, 32'h2222_2221);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      rd(OFS_CONFIG_LOCK, 32'h0000_0000);
      rd(OFS_CFG_LOWER, 32'h4444_4444);
      wr(OFS_CFG_LOWER, 32'h2222_2222);
      rd(OFS_CFG_LOWER, 32'h2222_2222);
      wr(OFS_CFG_UPPER, 32'h0000_0000);
      repeat (4) @(posedge clk_sys);
      rd(OFS_INPUT_LEVEL, 32'h0000_0000);
      tally_and_finish();
   end
endmodule
`default_nettype wire
